/* hw/stop_seq_pkg.sv */
// shared constants and types for the drive stop-sequence selector
package stop_seq_pkg;
   // -------------------------------------------------------------
   // object indices
   // -------------------------------------------------------------
   localparam logic [15:0] IDX_STOP_RAMP_SELECT_SERVO_OFF = 16'h3506;
   localparam logic [15:0] IDX_SHUTDOWN_STOP_METHOD = 16'h605b;
   localparam logic [15:0] IDX_PROFILE_DECEL_RATE = 16'h6084;
   localparam logic [15:0] IDX_QUICK_STOP_DECEL_RATE = 16'h6085;
   localparam logic [15:0] IDX_TORQUE_RAMP_RATE = 16'h6087;
   localparam logic [15:0] IDX_HOMING_ACCEL_RATE = 16'h609a;
   localparam logic [15:0] IDX_MAX_DECEL_RATE = 16'h60c6;

   // -------------------------------------------------------------
   // fields, reset values, thresholds
   // -------------------------------------------------------------
   localparam int CW_QUICK_STOP_BIT = 2;
   localparam logic [15:0] METHOD_SERVO_OFF = 16'h0000;
   localparam logic [15:0] METHOD_MODE_RAMP = 16'h0001;
   localparam logic [15:0] RST_SHUTDOWN_STOP_METHOD = 16'h0000;
   localparam logic [15:0] RST_STOP_RAMP_SELECT = 16'h0000;
   localparam logic [31:0] RST_RATE = 32'h0000_0000;
   localparam logic [31:0] STOP_VEL_RPM = 32'h0000_001e;

   // -------------------------------------------------------------
   // operation mode codes
   // -------------------------------------------------------------
   localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
   localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
   localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
   localparam logic [7:0] MODE_HOMING = 8'h06;
   localparam logic [7:0] MODE_INTERPOLATED_POSITION = 8'h07;
   localparam logic [7:0] MODE_CYCLIC_POSITION = 8'h08;
   localparam logic [7:0] MODE_CYCLIC_VELOCITY = 8'h09;
   localparam logic [7:0] MODE_CYCLIC_TORQUE = 8'h0a;

   typedef enum logic [2:0] {
      PDS_SWITCH_ON_DISABLED,
      PDS_READY_TO_SWITCH_ON,
      PDS_OPERATION_ENABLED,
      PDS_QUICK_STOP_DECEL,
      PDS_QUICK_STOP_ACTIVE,
      PDS_SHUTDOWN_DECEL,
      PDS_DISABLE_VOLTAGE_DECEL
   } pds_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] index;
      logic [31:0] wdata;
   } obj_req_s;

   typedef struct packed {
      logic servo_off_seq;
      logic [31:0] rate;
   } stop_sel_s;

   typedef struct packed {
      pds_e power_drive_state_machine;
      pds_e report;
      logic cw_qs_prev;
      logic decel_active;
      stop_sel_s sel;
      logic ack;
      logic err;
      logic [31:0] rdata;
      logic [15:0] stop_ramp_select_servo_off;
      logic method_mode_ramp;
      logic [31:0] profile_decel_rate;
      logic [31:0] quick_stop_decel_rate;
      logic [31:0] torque_ramp_rate;
      logic [31:0] homing_accel_rate;
      logic [31:0] max_decel_rate;
   } state_s;
endpackage : stop_seq_pkg

/* hw/drive_stop_sequence_select.sv */
// power_drive_state_machine stop-sequence selection with object registers
//
// Operation
// - quick-stop bit one-to-zero starts quick-stop deceleration
// - report Quick stop active while decelerating
// - stopped once speed at or below 30 r/min
// - after quick stop: Switch on disabled or stay
// - shutdown method chooses stop for Shutdown/Disable voltage
// - method accepts only zero or one
// - zero: servo-off sequence, then command's end state
// - one in homing: homing acceleration ramp
// - one: torque slope or profile deceleration
// - Shutdown deceleration still reports Operation enabled
`timescale 1ns/1ps
module drive_stop_sequence_select #(
   parameter int VEL_W = 32
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire stop_seq_pkg::obj_req_s obj_req,
   output logic obj_ack,
   output logic obj_err,
   output logic [31:0] obj_rdata,
   input wire logic [15:0] control_word,
   input wire logic cmd_shutdown,
   input wire logic cmd_disable_voltage,
   input wire logic cmd_enable_operation,
   input wire logic qs_end_disabled,
   input wire logic [7:0] op_mode,
   input wire logic signed [VEL_W-1:0] actual_velocity,
   output stop_seq_pkg::pds_e pds_state,
   output logic decel_active,
   output logic use_servo_off_seq,
   output logic [15:0] servo_off_seq_code,
   output logic [31:0] decel_rate
);
   // -------------------------------------------------------------
   // parameter check
   // -------------------------------------------------------------
   generate
      if (VEL_W < 8 || VEL_W > 32) begin : g_bad_width
         $error("VEL_W must lie between 8 and 32");
      end
   endgenerate

   stop_seq_pkg::state_s st_r;
   stop_seq_pkg::state_s st_nxt;
   logic [VEL_W-1:0] vel_abs;
   logic stopped;

   // -------------------------------------------------------------
   // stop method decode, shared by shutdown and disable voltage
   // -------------------------------------------------------------
   function automatic stop_seq_pkg::stop_sel_s pick_stop(
      input logic mode_ramp,
      input logic [7:0] mode,
      input stop_seq_pkg::state_s s
   );
      stop_seq_pkg::stop_sel_s r;
      r.servo_off_seq = 1'b1;
      r.rate = s.max_decel_rate;
      if (mode_ramp) begin
         r.servo_off_seq = 1'b0;
         case (mode)
            stop_seq_pkg::MODE_HOMING: begin
               r.rate = s.homing_accel_rate;
            end
            stop_seq_pkg::MODE_PROFILE_TORQUE,
            stop_seq_pkg::MODE_CYCLIC_TORQUE: begin
               r.rate = s.torque_ramp_rate;
            end
            default: begin
               r.rate = s.profile_decel_rate;
            end
         endcase
      end
      return r;
   endfunction : pick_stop

   // reported state hides the internal deceleration phases
   function automatic stop_seq_pkg::pds_e report_of(
      input stop_seq_pkg::pds_e p
   );
      case (p)
         stop_seq_pkg::PDS_QUICK_STOP_DECEL:
            return stop_seq_pkg::PDS_QUICK_STOP_ACTIVE;
         stop_seq_pkg::PDS_SHUTDOWN_DECEL,
         stop_seq_pkg::PDS_DISABLE_VOLTAGE_DECEL:
            return stop_seq_pkg::PDS_OPERATION_ENABLED;
         default:
            return p;
      endcase
   endfunction : report_of

   // -------------------------------------------------------------
   // speed threshold
   // -------------------------------------------------------------
   // velocity comes from the drive's own loop, so no synchroniser
   assign vel_abs = actual_velocity[VEL_W-1] ? 
      VEL_W'(-actual_velocity) : VEL_W'(actual_velocity);
   assign stopped = (32'(vel_abs) <= stop_seq_pkg::STOP_VEL_RPM);

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.cw_qs_prev = control_word[stop_seq_pkg::CW_QUICK_STOP_BIT];

      if (obj_req.wr || obj_req.rd) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = 32'h0000_0000;
         case (obj_req.index)
            stop_seq_pkg::IDX_STOP_RAMP_SELECT_SERVO_OFF: begin
               if (obj_req.wr) begin
                  st_nxt.stop_ramp_select_servo_off = obj_req.wdata[15:0];
               end
               st_nxt.rdata = {16'h0000, st_r.stop_ramp_select_servo_off};
            end
            stop_seq_pkg::IDX_SHUTDOWN_STOP_METHOD: begin
               if (obj_req.wr) begin
                  if (obj_req.wdata[15:0] == stop_seq_pkg::METHOD_SERVO_OFF ||
                      obj_req.wdata[15:0] == stop_seq_pkg::METHOD_MODE_RAMP)
                  begin
                     st_nxt.method_mode_ramp = obj_req.wdata[0];
                  end else begin
                     st_nxt.err = 1'b1;
                  end
               end
               st_nxt.rdata = {31'h0000_0000, st_r.method_mode_ramp};
            end
            stop_seq_pkg::IDX_PROFILE_DECEL_RATE: begin
               if (obj_req.wr) st_nxt.profile_decel_rate = obj_req.wdata;
               st_nxt.rdata = st_r.profile_decel_rate;
            end
            stop_seq_pkg::IDX_QUICK_STOP_DECEL_RATE: begin
               if (obj_req.wr) st_nxt.quick_stop_decel_rate = obj_req.wdata;
               st_nxt.rdata = st_r.quick_stop_decel_rate;
            end
            stop_seq_pkg::IDX_TORQUE_RAMP_RATE: begin
               if (obj_req.wr) st_nxt.torque_ramp_rate = obj_req.wdata;
               st_nxt.rdata = st_r.torque_ramp_rate;
            end
            stop_seq_pkg::IDX_HOMING_ACCEL_RATE: begin
               if (obj_req.wr) st_nxt.homing_accel_rate = obj_req.wdata;
               st_nxt.rdata = st_r.homing_accel_rate;
            end
            stop_seq_pkg::IDX_MAX_DECEL_RATE: begin
               if (obj_req.wr) st_nxt.max_decel_rate = obj_req.wdata;
               st_nxt.rdata = st_r.max_decel_rate;
            end
            default: begin
               st_nxt.err = 1'b1;
            end
         endcase
      end

      case (st_r.power_drive_state_machine)
         stop_seq_pkg::PDS_SWITCH_ON_DISABLED: begin
            if (cmd_shutdown) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_READY_TO_SWITCH_ON;
            end
         end
         stop_seq_pkg::PDS_READY_TO_SWITCH_ON: begin
            if (cmd_disable_voltage) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_SWITCH_ON_DISABLED;
            end else if (cmd_enable_operation) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_OPERATION_ENABLED;
            end
         end
         stop_seq_pkg::PDS_OPERATION_ENABLED: begin
            // quick stop outranks the voltage commands
            if (st_r.cw_qs_prev &&
                !control_word[stop_seq_pkg::CW_QUICK_STOP_BIT]) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_QUICK_STOP_DECEL;
               st_nxt.sel.servo_off_seq = 1'b0;
               st_nxt.sel.rate = st_r.quick_stop_decel_rate;
            end else if (cmd_disable_voltage) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_DISABLE_VOLTAGE_DECEL;
               st_nxt.sel = pick_stop(st_r.method_mode_ramp, op_mode,
                  st_r);
            end else if (cmd_shutdown) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_SHUTDOWN_DECEL;
               st_nxt.sel = pick_stop(st_r.method_mode_ramp, op_mode,
                  st_r);
            end
         end
         stop_seq_pkg::PDS_QUICK_STOP_DECEL: begin
            if (stopped) begin
               st_nxt.power_drive_state_machine = qs_end_disabled ?
                  stop_seq_pkg::PDS_SWITCH_ON_DISABLED :
                  stop_seq_pkg::PDS_QUICK_STOP_ACTIVE;
            end
         end
         stop_seq_pkg::PDS_QUICK_STOP_ACTIVE: begin
            if (cmd_disable_voltage) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_SWITCH_ON_DISABLED;
            end
         end
         stop_seq_pkg::PDS_SHUTDOWN_DECEL: begin
            if (stopped) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_READY_TO_SWITCH_ON;
            end
         end
         stop_seq_pkg::PDS_DISABLE_VOLTAGE_DECEL: begin
            if (stopped) begin
               st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_SWITCH_ON_DISABLED;
            end
         end
         default: begin
            st_nxt.power_drive_state_machine = stop_seq_pkg::PDS_SWITCH_ON_DISABLED;
         end
      endcase

      st_nxt.report = report_of(st_nxt.power_drive_state_machine);
      st_nxt.decel_active = (st_nxt.power_drive_state_machine ==
         stop_seq_pkg::PDS_QUICK_STOP_DECEL) ||
         (st_nxt.power_drive_state_machine == stop_seq_pkg::PDS_SHUTDOWN_DECEL) ||
         (st_nxt.power_drive_state_machine == stop_seq_pkg::PDS_DISABLE_VOLTAGE_DECEL);
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.power_drive_state_machine <= stop_seq_pkg::PDS_SWITCH_ON_DISABLED;
         st_r.report <= stop_seq_pkg::PDS_SWITCH_ON_DISABLED;
         st_r.cw_qs_prev <= 1'b0;
         st_r.stop_ramp_select_servo_off <=
            stop_seq_pkg::RST_STOP_RAMP_SELECT;
         st_r.method_mode_ramp <= stop_seq_pkg::RST_SHUTDOWN_STOP_METHOD[0];
         st_r.profile_decel_rate <= stop_seq_pkg::RST_RATE;
         st_r.quick_stop_decel_rate <= stop_seq_pkg::RST_RATE;
         st_r.torque_ramp_rate <= stop_seq_pkg::RST_RATE;
         st_r.homing_accel_rate <= stop_seq_pkg::RST_RATE;
         st_r.max_decel_rate <= stop_seq_pkg::RST_RATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign obj_ack = st_r.ack;
   assign obj_err = st_r.err;
   assign obj_rdata = st_r.rdata;
   assign pds_state = st_r.report;
   assign decel_active = st_r.decel_active;
   assign use_servo_off_seq = st_r.sel.servo_off_seq;
   assign servo_off_seq_code = st_r.stop_ramp_select_servo_off;
   assign decel_rate = st_r.sel.rate;
endmodule : drive_stop_sequence_select

/* tb/drive_stop_sequence_select_sva.sv */
// port checker for the stop-sequence selector
`timescale 1ns/1ps
module stop_seq_checker #(
   parameter int VEL_W = 32
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire stop_seq_pkg::obj_req_s obj_req,
   input wire logic obj_ack,
   input wire logic obj_err,
   input wire logic [31:0] obj_rdata,
   input wire logic [15:0] control_word,
   input wire logic cmd_shutdown,
   input wire logic cmd_disable_voltage,
   input wire logic signed [VEL_W-1:0] actual_velocity,
   input wire stop_seq_pkg::pds_e pds_state,
   input wire logic decel_active
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   logic slow;
   logic open;
   logic run;
   assign slow = actual_velocity <= 30 && actual_velocity >= -30;
   assign open = pds_state == stop_seq_pkg::PDS_OPERATION_ENABLED;
   assign run = open && !decel_active;
   // ----------------------------------------------------------
   // sequences and properties
   // ----------------------------------------------------------
   sequence qs_edge_s;
      control_word[2] ##1 !control_word[2] && run;
   endsequence
   sequence stop_s;
      decel_active && slow;
   endsequence
   a_ack_follows: assert property (obj_req.wr || obj_req.rd |=> obj_ack)
      else $error("request not acknowledged");
   a_err_with_ack: assert property (obj_err |-> obj_ack)
      else $error("error without ack");
   a_method_refuse: assert property (
      obj_req.wr && obj_req.index == 16'h605b &&
      obj_req.wdata[15:0] > 16'h0001
      |=> obj_err && obj_ack) else $error("bad method write accepted");
   a_method_range: assert property (
      obj_ack && !obj_err && $past(obj_req.index) == 16'h605b
      |-> obj_rdata[31:1] == 31'h0) else $error("method out of range");
   a_qs_start: assert property (qs_edge_s |=> decel_active &&
      pds_state == stop_seq_pkg::PDS_QUICK_STOP_ACTIVE)
      else $error("quick stop not started");
   a_decel_report: assert property (decel_active |-> open ||
      pds_state == stop_seq_pkg::PDS_QUICK_STOP_ACTIVE)
      else $error("wrong state during deceleration");
   a_stop_speed: assert property (stop_s |=> !decel_active)
      else $error("deceleration did not end");
   a_qs_end: assert property (
      stop_s ##0 pds_state == stop_seq_pkg::PDS_QUICK_STOP_ACTIVE |=>
      pds_state inside {stop_seq_pkg::PDS_QUICK_STOP_ACTIVE,
      stop_seq_pkg::PDS_SWITCH_ON_DISABLED})
      else $error("wrong state after quick stop");
   a_shutdown_start: assert property (
      cmd_shutdown && !cmd_disable_voltage && control_word[2] && run
      |=> decel_active && open) else $error("shutdown not started");
   a_shutdown_hold: assert property (
      decel_active && open && !slow |=> decel_active && open)
      else $error("shutdown ended early");
endmodule : stop_seq_checker

/* tb/bus_master_model.sv */
// master-side model: object access and power-drive commands
`timescale 1ns/1ps
module bus_master_model (
   input wire logic clk_sys,
   input wire logic obj_ack,
   input wire logic obj_err,
   input wire logic [31:0] obj_rdata,
   output stop_seq_pkg::obj_req_s obj_req,
   output logic [15:0] control_word,
   output logic cmd_shutdown,
   output logic cmd_disable_voltage,
   output logic cmd_enable_operation
);
   // idle master: no request, quick-stop bit high so no false edge
   initial begin
      obj_req <= '0;
      control_word <= 16'h0004;
      {cmd_shutdown, cmd_disable_voltage, cmd_enable_operation} <= 3'b000;
   end
   // answer is registered on the taking edge and read 1 ns after it
   task automatic access(input logic wr, input logic [15:0] idx,
         input logic [31:0] wd, output logic [31:0] rd_v,
         output logic err, output logic ok);
      @(posedge clk_sys);
      obj_req <= '{wr: wr, rd: !wr, index: idx, wdata: wd};
      @(posedge clk_sys);
      obj_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~wd};
      #1;
      ok = obj_ack;
      rd_v = obj_rdata;
      err = obj_err;
   endtask : access
   // 0 shutdown, 1 disable voltage, 2 enable, 3 drop, 4 raise quick stop
   task automatic command(input int which);
      @(posedge clk_sys);
      case (which)
         0: cmd_shutdown <= 1'b1;
         1: cmd_disable_voltage <= 1'b1;
         2: cmd_enable_operation <= 1'b1;
         3: control_word[2] <= 1'b0;
         default: control_word[2] <= 1'b1;
      endcase
      @(posedge clk_sys);
      {cmd_shutdown, cmd_disable_voltage, cmd_enable_operation} <= 3'b000;
      #1;
   endtask : command
endmodule : bus_master_model

/* tb/drive_stop_sequence_select_bench.sv */
// self-checking bench for the stop-sequence selector
`timescale 1ns/1ps
module drive_stop_sequence_select_bench;
   localparam int VEL_W = 16;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   stop_seq_pkg::obj_req_s obj_req;
   stop_seq_pkg::pds_e pds_state;
   logic [31:0] obj_rdata, decel_rate, rd_v;
   logic [15:0] control_word, servo_off_seq_code;
   logic obj_ack, obj_err, err, ok, decel_active, use_servo_off_seq;
   logic cmd_shutdown, cmd_disable_voltage, cmd_enable_operation;
   logic qs_end_disabled;
   logic [7:0] op_mode;
   logic signed [VEL_W-1:0] actual_velocity;
   logic [15:0] idx_tbl [7] = '{16'h3506, 16'h605b, 16'h6084, 16'h6085,
      16'h6087, 16'h609a, 16'h60c6};
   logic [7:0] modes [8] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08,
      8'h09, 8'h0a};
   int fails = 0;
   int tests_run = 0;
   always #12.5 clk_sys = ~clk_sys;
   drive_stop_sequence_select #(.VEL_W(VEL_W)) u_dut (.clk_sys(clk_sys),
      .rstn(rstn), .obj_req(obj_req), .obj_ack(obj_ack), .obj_err(obj_err),
      .obj_rdata(obj_rdata), .control_word(control_word),
      .cmd_shutdown(cmd_shutdown), .cmd_disable_voltage(cmd_disable_voltage),
      .cmd_enable_operation(cmd_enable_operation),
      .qs_end_disabled(qs_end_disabled), .op_mode(op_mode),
      .actual_velocity(actual_velocity), .pds_state(pds_state),
      .decel_active(decel_active), .use_servo_off_seq(use_servo_off_seq),
      .servo_off_seq_code(servo_off_seq_code), .decel_rate(decel_rate));
   bus_master_model u_master (.clk_sys(clk_sys), .obj_ack(obj_ack),
      .obj_err(obj_err), .obj_rdata(obj_rdata), .obj_req(obj_req),
      .control_word(control_word), .cmd_shutdown(cmd_shutdown),
      .cmd_disable_voltage(cmd_disable_voltage),
      .cmd_enable_operation(cmd_enable_operation));
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] wval(input logic [15:0] idx);
      if (idx == 16'h605b)
         return 32'h1;
      return (idx == 16'h3506) ? 32'ha5c3_0007 : {16'ha5c3, idx};
   endfunction : wval
   task automatic check_val(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val
   task automatic obj(input logic wr, input logic [15:0] idx,
         input logic [31:0] wd);
      u_master.access(wr, idx, wd, rd_v, err, ok);
      check_val("ack", 32'h1, 32'(ok));
   endtask : obj
   // 31 is just above the stop threshold, -30 is on it
   task automatic stop_motor();
      @(posedge clk_sys);
      actual_velocity <= 16'sd31;
      repeat (3) @(posedge clk_sys);
      check_val("moving", 32'h1, 32'(decel_active));
      actual_velocity <= -16'sd30;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         #1;
         if (!decel_active)
            break;
      end
      check_val("stopped", 32'h0, 32'(decel_active));
      if (decel_active)
         complete_run();
   endtask : stop_motor
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      qs_end_disabled <= 1'b0;
      op_mode <= 8'h01;
      actual_velocity <= '0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      foreach (idx_tbl[i]) begin
         obj(1'b1, idx_tbl[i], wval(idx_tbl[i]));
         check_val("reset value", 32'h0, rd_v);
      end
      foreach (idx_tbl[i]) begin
         obj(1'b0, idx_tbl[i], 32'h0);
         check_val("readback", idx_tbl[i] == 16'h3506 ? 32'h7 :
            wval(idx_tbl[i]), rd_v);
      end
      obj(1'b0, 16'h1234, 32'h0);
      check_val("unmapped data", 32'h0, rd_v);
      check_val("unmapped err", 32'h1, 32'(err));
      check_val("seq code", 32'h7, 32'(servo_off_seq_code));
      $display("test objects done");
      obj(1'b1, 16'h605b, 32'h2);
      check_val("method err", 32'h1, 32'(err));
      obj(1'b1, 16'h605b, 32'hffff);
      check_val("method err", 32'h1, 32'(err));
      obj(1'b0, 16'h605b, 32'h0);
      check_val("method kept", 32'h1, rd_v);
      $display("test method range done");
      for (int m = 0; m < 2; m++) begin
         obj(1'b1, 16'h605b, 32'(m));
         foreach (modes[k]) begin
            @(posedge clk_sys);
            op_mode <= modes[k];
            actual_velocity <= 16'sd1000;
            u_master.command(0);
            u_master.command(2);
            u_master.command(k % 2);
            check_val("decel", 32'h1, 32'(decel_active));
            check_val("state", 32'(stop_seq_pkg::PDS_OPERATION_ENABLED),
               32'(pds_state));
            check_val("servo off", 32'(m == 0),
               32'(use_servo_off_seq));
            check_val("rate", wval(m == 0 ? 16'h60c6 : modes[k] == 8'h06
               ? 16'h609a : modes[k] inside {8'h04, 8'h0a} ? 16'h6087 :
               16'h6084), decel_rate);
            stop_motor();
            check_val("end", 32'(k % 2 ? stop_seq_pkg::PDS_SWITCH_ON_DISABLED
               : stop_seq_pkg::PDS_READY_TO_SWITCH_ON),
               32'(pds_state));
            if (k % 2 == 0)
               u_master.command(1);
         end
      end
      $display("test shutdown modes done");
      for (int q = 0; q < 2; q++) begin
         @(posedge clk_sys);
         qs_end_disabled <= q[0];
         actual_velocity <= 16'sd500;
         u_master.command(0);
         u_master.command(2);
         u_master.command(3);
         check_val("qs state", 32'(stop_seq_pkg::PDS_QUICK_STOP_ACTIVE),
            32'(pds_state));
         check_val("qs rate", wval(16'h6085), decel_rate);
         stop_motor();
         check_val("qs end", 32'(q ? stop_seq_pkg::PDS_SWITCH_ON_DISABLED :
            stop_seq_pkg::PDS_QUICK_STOP_ACTIVE), 32'(pds_state));
         u_master.command(4);
         if (q == 0)
            u_master.command(1);
      end
      $display("test quick stop done");
      complete_run();
   end
endmodule : drive_stop_sequence_select_bench
bind drive_stop_sequence_select stop_seq_checker #(.VEL_W(VEL_W)) u_chk (
   .clk_sys(clk_sys), .rstn(rstn), .obj_req(obj_req), .obj_ack(obj_ack),
   .obj_err(obj_err), .obj_rdata(obj_rdata), .control_word(control_word),
   .cmd_shutdown(cmd_shutdown), .cmd_disable_voltage(cmd_disable_voltage),
   .actual_velocity(actual_velocity), .pds_state(pds_state),
   .decel_active(decel_active));
